// ### hdl/watchpoint_unit.v
`timescale 1ns/1ps
`include "watch_consts.vh"

module watchpoint_unit
#(
   parameter NUM_WATCH = 4
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire mem_valid,
   input wire mem_is_load,
   input wire [2:0] mem_thread,
   input wire [31:0] mem_address,
   input wire res_valid,
   input wire [2:0] res_thread,
   input wire [31:0] res_id,
   output reg debug_irq,
   output reg [31:0] debug_cause_record,
   output reg [31:0] debug_capture_value
);
   // ****************************************************************
   // register storage
   // ****************************************************************
   reg [31:0] data_watch_first_address [0:NUM_WATCH-1];
   reg [31:0] data_watch_second_address [0:NUM_WATCH-1];
   reg [31:0] data_watch_control [0:NUM_WATCH-1];
   reg [31:0] resource_watch_mask [0:NUM_WATCH-1];
   reg [31:0] resource_watch_value [0:NUM_WATCH-1];
   reg [31:0] resource_watch_control [0:NUM_WATCH-1];

   wire [NUM_WATCH-1:0] data_hit;
   wire [NUM_WATCH-1:0] res_hit;
   wire [7:0] idx;
   wire [1:0] sub;
   wire setup;
   wire wr_commit;
   wire sel_dw_first;
   wire sel_dw_second;
   wire sel_dw_ctrl;
   wire sel_rw_mask;
   wire sel_rw_value;
   wire sel_rw_ctrl;
   wire sel_cause;
   wire sel_capture;
   wire mapped;

   assign idx = paddr[9:2];
   assign sub = idx[1:0];
   assign setup = psel & ~penable;
   // refused accesses must store nothing
   assign wr_commit = psel & penable & pready & pwrite & mapped;
   assign sel_dw_first = {2'h0, idx[7:2]} == (`IDX_DW_FIRST >> 2); // [RL1]
   assign sel_dw_second = {2'h0, idx[7:2]} == (`IDX_DW_SECOND >> 2); // [RL2]
   assign sel_dw_ctrl = {2'h0, idx[7:2]} == (`IDX_DW_CTRL >> 2); // [RL3]
   assign sel_rw_mask = {2'h0, idx[7:2]} == (`IDX_RW_MASK >> 2); // [RL8]
   assign sel_rw_value = {2'h0, idx[7:2]} == (`IDX_RW_VALUE >> 2); // [RL9]
   assign sel_rw_ctrl = {2'h0, idx[7:2]} == (`IDX_RW_CTRL >> 2); // [RL10]
   assign sel_cause = idx == `IDX_CAUSE;
   assign sel_capture = idx == `IDX_CAPTURE;
   assign mapped = (paddr[31:10] == 22'h00_0000) & (paddr[1:0] == 2'h0)
                   & (sel_dw_first | sel_dw_second | sel_dw_ctrl
                      | sel_rw_mask | sel_rw_value | sel_rw_ctrl
                      | sel_cause | sel_capture);

   // ****************************************************************
   // per-watchpoint comparators
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_WATCH; g = g + 1)
      begin : gen_watch
         data_watch_match u_data
         (
            .first_address(data_watch_first_address[g]),
            .second_address(data_watch_second_address[g]),
            .control(data_watch_control[g]),
            .mem_valid(mem_valid),
            .mem_is_load(mem_is_load),
            .mem_thread(mem_thread),
            .mem_address(mem_address),
            .hit(data_hit[g])
         );
         resource_watch_match u_res
         (
            .mask(resource_watch_mask[g]),
            .value(resource_watch_value[g]),
            .control(resource_watch_control[g]),
            .res_valid(res_valid),
            .res_thread(res_thread),
            .res_id(res_id),
            .hit(res_hit[g])
         );
      end
   endgenerate

   // ****************************************************************
   // hit priority: data before resource, lowest number first
   // ****************************************************************
   reg any_hit;
   reg [2:0] hit_code;
   reg [1:0] hit_num;
   reg [2:0] hit_thread;
   reg [31:0] hit_value;
   integer k;

   always @*
   begin
      any_hit = 1'b0;
      hit_code = `CAUSE_DATA_WATCH;
      hit_num = 2'h0;
      hit_thread = 3'h0;
      hit_value = 32'h0000_0000;
      for (k = NUM_WATCH - 1; k >= 0; k = k - 1)
      begin
         if (res_hit[k])
         begin
            any_hit = 1'b1;
            hit_code = `CAUSE_RES_WATCH; // [RL13]
            hit_num = k[1:0]; // [RL15]
            hit_thread = res_thread; // [RL15]
            hit_value = res_id; // [RL14]
         end
      end
      for (k = NUM_WATCH - 1; k >= 0; k = k - 1)
      begin
         if (data_hit[k])
         begin
            any_hit = 1'b1;
            hit_code = `CAUSE_DATA_WATCH; // [RL13]
            hit_num = k[1:0]; // [RL15]
            hit_thread = mem_thread; // [RL15]
            hit_value = mem_address; // [RL14]
         end
      end
   end

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   integer i;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (i = 0; i < NUM_WATCH; i = i + 1)
         begin
            data_watch_first_address[i] <= `REG_RESET;
            data_watch_second_address[i] <= `REG_RESET;
            data_watch_control[i] <= `REG_RESET; // [RL4]
            resource_watch_mask[i] <= `REG_RESET;
            resource_watch_value[i] <= `REG_RESET;
            resource_watch_control[i] <= `REG_RESET; // [RL11]
         end
      end
      else if (wr_commit)
      begin
         if (sel_dw_first)
            data_watch_first_address[sub] <= pwdata; // [RL1]
         if (sel_dw_second)
            data_watch_second_address[sub] <= pwdata; // [RL2]
         if (sel_dw_ctrl)
            data_watch_control[sub] <= pwdata & `DW_CTRL_WMASK; // [RL3]
         if (sel_rw_mask)
            resource_watch_mask[sub] <= pwdata; // [RL8]
         if (sel_rw_value)
            resource_watch_value[sub] <= pwdata; // [RL9]
         if (sel_rw_ctrl)
            resource_watch_control[sub] <= pwdata & `RW_CTRL_WMASK; // [RL10]
      end
   end

   // ****************************************************************
   // cause record and capture; a hit wins over a software write
   // ****************************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         debug_irq <= 1'b0;
         debug_cause_record <= `REG_RESET;
         debug_capture_value <= `REG_RESET;
      end
      else
      begin
         debug_irq <= any_hit;
         if (any_hit)
         begin
            debug_cause_record <= {14'h0000, hit_num, 5'h00, hit_thread,
                                   5'h00, hit_code}; // [RL13] [RL15]
            debug_capture_value <= hit_value; // [RL14]
         end
         else if (wr_commit)
         begin
            if (sel_cause)
               debug_cause_record <= pwdata & `CAUSE_WMASK;
            if (sel_capture)
               debug_capture_value <= pwdata;
         end
      end
   end

   // ****************************************************************
   // apb answer: one access cycle, data loaded at setup
   // ****************************************************************
   reg [31:0] next_prdata;

   always @*
   begin
      next_prdata = 32'h0000_0000;
      if (sel_dw_first)
         next_prdata = data_watch_first_address[sub];
      else if (sel_dw_second)
         next_prdata = data_watch_second_address[sub];
      else if (sel_dw_ctrl)
         next_prdata = data_watch_control[sub];
      else if (sel_rw_mask)
         next_prdata = resource_watch_mask[sub];
      else if (sel_rw_value)
         next_prdata = resource_watch_value[sub];
      else if (sel_rw_ctrl)
         next_prdata = resource_watch_control[sub];
      else if (sel_cause)
         next_prdata = debug_cause_record;
      else if (sel_capture)
         next_prdata = debug_capture_value;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         if (setup & ~pwrite & mapped)
            prdata <= next_prdata;
         else if (setup)
            prdata <= 32'h0000_0000;
      end
   end
endmodule

// ### hdl/watch_consts.vh
// Notes on behaviour
// [RL1] four data watchpoints, 32-bit first address at indices 0x50..0x53
// [RL2] four 32-bit second address registers at indices 0x60..0x63
// [RL3] one data watch control register each, indices 0x70..0x73
// [RL4] data control bits 23:16 enable per thread, reset zero
// [RL5] data control bit 2 also evaluates loads, reset zero
// [RL6] data control bit 1: 0 needs A and B, 1 needs A or B
// [RL7] data control bit 0 enables watchpoint; clear means never triggers
// [RL8] four resource watchpoints, 32-bit mask at indices 0x80..0x83
// [RL9] four 32-bit resource compare values at indices 0x90..0x93
// [RL10] one resource control register each, indices 0x9C..0x9F
// [RL11] resource control bits 23:16 thread enables, bit 0 enable, reset zero
// [RL12] resource control bit 1: 0 fires on A, 1 fires on B
// [RL13] hit records cause code 4 for data, 5 for resource
// [RL14] capture effective address on data hit, resource id on resource hit
// [RL15] simultaneous hits report a data hit before a resource hit, then the lowest-numbered watchpoint and its thread
// [RL16] data A: address at or above first; B: address at or below second
// [RL17] resource A: masked id equals value; B: masked id differs
`ifndef WATCH_CONSTS_VH
`define WATCH_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_DW_FIRST 8'h50
`define IDX_DW_SECOND 8'h60
`define IDX_DW_CTRL 8'h70
`define IDX_RW_MASK 8'h80
`define IDX_RW_VALUE 8'h90
`define IDX_RW_CTRL 8'h9C
`define IDX_CAUSE 8'h15
`define IDX_CAPTURE 8'h16

// control register fields
`define CTRL_THREAD_HI 23
`define CTRL_THREAD_LO 16
`define CTRL_LOAD_BIT 2
`define CTRL_COND_BIT 1
`define CTRL_ENABLE_BIT 0
`define DW_CTRL_WMASK 32'h00FF_0007
`define RW_CTRL_WMASK 32'h00FF_0003

// cause record fields and codes
`define CAUSE_NUM_HI 17
`define CAUSE_NUM_LO 16
`define CAUSE_THR_HI 15
`define CAUSE_THR_LO 8
`define CAUSE_CODE_HI 2
`define CAUSE_CODE_LO 0
`define CAUSE_WMASK 32'h0003_FF07
`define CAUSE_DATA_WATCH 3'h4
`define CAUSE_RES_WATCH 3'h5

`define REG_RESET 32'h0000_0000

`endif

// ### hdl/data_watch_match.v
`timescale 1ns/1ps
`include "watch_consts.vh"

module data_watch_match
(
   input wire [31:0] first_address,
   input wire [31:0] second_address,
   input wire [31:0] control,
   input wire mem_valid,
   input wire mem_is_load,
   input wire [2:0] mem_thread,
   input wire [31:0] mem_address,
   output wire hit
);
   wire cond_a;
   wire cond_b;
   wire combined;
   wire op_ok;
   wire thread_ok;

   assign cond_a = mem_address >= first_address; // [RL16]
   assign cond_b = mem_address <= second_address; // [RL16]
   assign combined = control[`CTRL_COND_BIT] ? (cond_a | cond_b)
                                             : (cond_a & cond_b); // [RL6]
   assign op_ok = ~mem_is_load | control[`CTRL_LOAD_BIT]; // [RL5]
   assign thread_ok = control[`CTRL_THREAD_LO + mem_thread]; // [RL4]
   assign hit = mem_valid & control[`CTRL_ENABLE_BIT] & op_ok & thread_ok
                & combined; // [RL7]
endmodule

// ### hdl/resource_watch_match.v
`timescale 1ns/1ps
`include "watch_consts.vh"

module resource_watch_match
(
   input wire [31:0] mask,
   input wire [31:0] value,
   input wire [31:0] control,
   input wire res_valid,
   input wire [2:0] res_thread,
   input wire [31:0] res_id,
   output wire hit
);
   wire cond_a;
   wire cond_b;
   wire chosen;
   wire thread_ok;

   assign cond_a = (res_id & mask) == value; // [RL17]
   assign cond_b = ~cond_a; // [RL17]
   assign chosen = control[`CTRL_COND_BIT] ? cond_b : cond_a; // [RL12]
   assign thread_ok = control[`CTRL_THREAD_LO + res_thread]; // [RL11]
   assign hit = res_valid & control[`CTRL_ENABLE_BIT] & thread_ok
                & chosen; // [RL11]
endmodule

// ### verification/watch_asserts.sv
`timescale 1ns/1ps
`include "watch_consts.vh"
// ****
// port checks
// ****
module watch_asserts
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready,
   input wire pslverr,
   input wire mem_valid,
   input wire [2:0] mem_thread,
   input wire [31:0] mem_address,
   input wire res_valid,
   input wire [31:0] res_id,
   input wire debug_irq,
   input wire [31:0] debug_cause_record,
   input wire [31:0] debug_capture_value
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable && pready;
   endsequence
   sequence data_hit_s;
      debug_irq && debug_cause_record[2:0] == `CAUSE_DATA_WATCH;
   endsequence
   a_ready_after_setup: assert property (setup_s |=> access_s)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_error_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_hit_cause_code: assert property (debug_irq |->
      debug_cause_record[2:0] inside {`CAUSE_DATA_WATCH, `CAUSE_RES_WATCH})
      else $error("bad cause code");
   a_hit_needs_op: assert property (debug_irq |->
      $past(mem_valid || res_valid)) else $error("hit without op");
   a_data_capture: assert property (data_hit_s |->
      debug_capture_value == $past(mem_address)) else $error("bad capture");
   a_res_capture: assert property (debug_irq &&
      debug_cause_record[2:0] == `CAUSE_RES_WATCH |->
      debug_capture_value == $past(res_id)) else $error("bad res capture");
   a_data_thread: assert property (data_hit_s |->
      debug_cause_record[15:8] == {5'h00, $past(mem_thread)})
      else $error("bad thread field");
   a_cause_steady: assert property (!debug_irq &&
      !$past(psel && penable && pwrite) |-> $stable(debug_cause_record))
      else $error("cause changed without hit");
endmodule

bind watchpoint_unit watch_asserts chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
   .pslverr(pslverr), .mem_valid(mem_valid), .mem_thread(mem_thread),
   .mem_address(mem_address), .res_valid(res_valid), .res_id(res_id),
   .debug_irq(debug_irq), .debug_cause_record(debug_cause_record),
   .debug_capture_value(debug_capture_value));

// ### verification/core_op_source.sv
`timescale 1ns/1ps
// ****
// core pipeline issuing one-cycle ops
// ****
module core_op_source
(
   input wire pclk,
   output logic mem_valid = 1'b0,
   output logic mem_is_load = 1'b0,
   output logic [2:0] mem_thread = 3'h0,
   output logic [31:0] mem_address = 32'h0000_0000,
   output logic res_valid = 1'b0,
   output logic [2:0] res_thread = 3'h0,
   output logic [31:0] res_id = 32'h0000_0000
);
   task mem_op(input logic ld, input logic [2:0] thr, input logic [31:0] a);
      @(posedge pclk);
      mem_valid <= 1'b1;
      mem_is_load <= ld;
      mem_thread <= thr;
      mem_address <= a;
      @(posedge pclk);
      mem_valid <= 1'b0;
      mem_thread <= ~thr;
      mem_address <= ~a;
   endtask
   task res_op(input logic [2:0] thr, input logic [31:0] id);
      @(posedge pclk);
      res_valid <= 1'b1;
      res_thread <= thr;
      res_id <= id;
      @(posedge pclk);
      res_valid <= 1'b0;
      res_thread <= ~thr;
      res_id <= ~id;
   endtask
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
`include "watch_consts.vh"
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   wire [31:0] prdata;
   wire pready, pslverr, mem_valid, mem_is_load, res_valid, debug_irq;
   wire [2:0] mem_thread, res_thread;
   wire [31:0] mem_address, res_id, debug_cause_record, debug_capture_value;
   logic [31:0] rdv;
   logic errv;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   core_op_source core (.pclk(pclk), .mem_valid(mem_valid),
      .mem_is_load(mem_is_load), .mem_thread(mem_thread),
      .mem_address(mem_address), .res_valid(res_valid),
      .res_thread(res_thread), .res_id(res_id));
   watchpoint_unit #(.NUM_WATCH(4)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_valid(mem_valid), .mem_is_load(mem_is_load),
      .mem_thread(mem_thread), .mem_address(mem_address),
      .res_valid(res_valid), .res_thread(res_thread), .res_id(res_id),
      .debug_irq(debug_irq), .debug_cause_record(debug_cause_record),
      .debug_capture_value(debug_capture_value));
   initial
   begin
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {22'h00_0000, idx, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] e);
      apb(1'b0, idx, 32'h0000_0000);
      check(nm, rdv, e);
   endtask
   task hit(input logic irq, input logic [31:0] cause, cap);
      #1;
      check("irq", {31'h0, debug_irq}, {31'h0, irq});
      if (irq)
      begin
         check("cause", debug_cause_record, cause);
         check("capture", debug_capture_value, cap);
      end
   endtask
   task t_regs;
      logic [7:0] i;
      for (i = 0; i < 4; i++)
      begin
         rd_chk("dctl rst", `IDX_DW_CTRL + i, 32'h0000_0000);
         rd_chk("rctl rst", `IDX_RW_CTRL + i, 32'h0000_0000);
         apb(1'b1, `IDX_DW_FIRST + i, {24'hA5_0001, i});
         apb(1'b1, `IDX_DW_SECOND + i, {24'hA5_0002, i});
         apb(1'b1, `IDX_RW_MASK + i, {24'hA5_0003, i});
         apb(1'b1, `IDX_RW_VALUE + i, {24'hA5_0004, i});
         apb(1'b1, `IDX_DW_CTRL + i, 32'hFFFF_FFFF);
         apb(1'b1, `IDX_RW_CTRL + i, 32'hFFFF_FFFF);
         rd_chk("first", `IDX_DW_FIRST + i, {24'hA5_0001, i});
         rd_chk("second", `IDX_DW_SECOND + i, {24'hA5_0002, i});
         rd_chk("mask", `IDX_RW_MASK + i, {24'hA5_0003, i});
         rd_chk("value", `IDX_RW_VALUE + i, {24'hA5_0004, i});
         rd_chk("dctl", `IDX_DW_CTRL + i, 32'h00FF_0007);
         rd_chk("rctl", `IDX_RW_CTRL + i, 32'h00FF_0003);
         apb(1'b1, `IDX_DW_CTRL + i, 32'h0000_0000);
         apb(1'b1, `IDX_RW_CTRL + i, 32'h0000_0000);
      end
      apb(1'b0, 8'h54, 32'h0000_0000);
      check("unmapped", {31'h0, errv}, 32'h0000_0001);
      check("err data", rdv, 32'h0000_0000);
      $display("register test done");
   endtask
   task t_data;
      apb(1'b1, `IDX_DW_FIRST + 8'h2, 32'h0000_0100);
      apb(1'b1, `IDX_DW_SECOND + 8'h2, 32'h0000_01FF);
      apb(1'b1, `IDX_DW_CTRL + 8'h2, 32'h0008_0001);
      core.mem_op(1'b0, 3'h3, 32'h0000_0180);
      hit(1'b1, 32'h0002_0304, 32'h0000_0180);
      core.mem_op(1'b0, 3'h4, 32'h0000_0180);
      hit(1'b0, 32'h0, 32'h0);
      core.mem_op(1'b1, 3'h3, 32'h0000_0180);
      hit(1'b0, 32'h0, 32'h0);
      apb(1'b1, `IDX_DW_CTRL + 8'h2, 32'h0008_0005);
      core.mem_op(1'b1, 3'h3, 32'h0000_0100);
      hit(1'b1, 32'h0002_0304, 32'h0000_0100);
      core.mem_op(1'b0, 3'h3, 32'h0000_0200);
      hit(1'b0, 32'h0, 32'h0);
      apb(1'b1, `IDX_DW_CTRL + 8'h2, 32'h0008_0003);
      core.mem_op(1'b0, 3'h3, 32'h0000_0200);
      hit(1'b1, 32'h0002_0304, 32'h0000_0200);
      apb(1'b1, `IDX_DW_CTRL + 8'h2, 32'h0008_0002);
      core.mem_op(1'b0, 3'h3, 32'h0000_0200);
      hit(1'b0, 32'h0, 32'h0);
      apb(1'b1, `IDX_DW_FIRST + 8'h1, 32'h0000_0100);
      apb(1'b1, `IDX_DW_SECOND + 8'h1, 32'h0000_01FF);
      apb(1'b1, `IDX_DW_CTRL + 8'h1, 32'h0008_0001);
      apb(1'b1, `IDX_DW_CTRL + 8'h2, 32'h0008_0001);
      core.mem_op(1'b0, 3'h3, 32'h0000_01FF);
      hit(1'b1, 32'h0001_0304, 32'h0000_01FF);
      rd_chk("cause reg", `IDX_CAUSE, 32'h0001_0304);
      rd_chk("capture reg", `IDX_CAPTURE, 32'h0000_01FF);
      apb(1'b1, `IDX_CAUSE, 32'hFFFF_FFFF);
      rd_chk("cause mask", `IDX_CAUSE, 32'h0003_FF07);
      apb(1'b1, `IDX_CAPTURE, 32'h0000_5A5A);
      rd_chk("capture wr", `IDX_CAPTURE, 32'h0000_5A5A);
      apb(1'b1, `IDX_DW_CTRL + 8'h1, 32'h0000_0000);
      apb(1'b1, `IDX_DW_CTRL + 8'h2, 32'h0000_0000);
      $display("data test done");
   endtask
   task t_res;
      apb(1'b1, `IDX_RW_MASK, 32'h0000_00FF);
      apb(1'b1, `IDX_RW_VALUE, 32'h0000_0012);
      apb(1'b1, `IDX_RW_CTRL, 32'h0020_0001);
      core.res_op(3'h5, 32'h1234_5612);
      hit(1'b1, 32'h0000_0505, 32'h1234_5612);
      core.res_op(3'h4, 32'h1234_5612);
      hit(1'b0, 32'h0, 32'h0);
      apb(1'b1, `IDX_RW_CTRL, 32'h0020_0003);
      core.res_op(3'h5, 32'h1234_5612);
      hit(1'b0, 32'h0, 32'h0);
      core.res_op(3'h5, 32'h1234_5613);
      hit(1'b1, 32'h0000_0505, 32'h1234_5613);
      $display("resource test done");
   endtask
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_data();
      t_res();
      tally_and_finish();
   end
endmodule
